// [sdcr_cfg.svh]
/*
 * Constants of the decode configuration bank: configuration offsets, reset values,
 * field positions, the clock-chip I/O range and the option-rom base.
 * Assumes it is included by bare name before any code that uses it.
 */
`ifndef SDCR_CFG_SVH
`define SDCR_CFG_SVH

`define SDCR_OFF_FEN_LO     8'h5a
`define SDCR_OFF_FEN_HI     8'h5b
`define SDCR_OFF_SIO        8'h5c
`define SDCR_OFF_SFE        8'h5d
`define SDCR_OFF_PPID       8'h5e
`define SDCR_OFF_PPM        8'h5f
`define SDCR_OFF_DRT3       8'h61
`define SDCR_OFF_ROM        8'h62

`define SDCR_FEN_STRAP_HI   16'hffbf
`define SDCR_FEN_STRAP_LO   16'h0000
`define SDCR_FEN_WMASK      16'hffbf
`define SDCR_SFE_RST        8'h00
`define SDCR_SFE_WMASK      8'h03
`define SDCR_PPM_RST        8'h00
`define SDCR_PPM_WMASK      8'h07
`define SDCR_DRT3_RST       8'h00
`define SDCR_DRT3_WMASK     8'h0f
`define SDCR_ROM_RST        8'h00
`define SDCR_SIO_RST        8'h00
`define SDCR_PPID_VAL       8'h5a

`define SDCR_FEN_RTC        8
`define SDCR_FEN_KBC        13
`define SDCR_SIO_PNF        0
`define SDCR_SIO_LOCK38     1
`define SDCR_SIO_LOCK19     2
`define SDCR_SIO_FIRSG      3
`define SDCR_SIO_ALTKBC     4
`define SDCR_SIO_BAUDT      5
`define SDCR_SIO_UIR        6
`define SDCR_SIO_KBRNG      7
`define SDCR_SFE_FDCCFG     0
`define SDCR_SFE_SERIRQ     1
`define SDCR_P92_LOCK38     3
`define SDCR_P92_LOCK19     5
`define SDCR_DRT3_EN        3
`define SDCR_DRT3_NONE      3'h4

`define SDCR_ROM_BASE       32'h000c0000
`define SDCR_ROM_WIN_LSB    14
`define SDCR_RTC_BASE       16'h0070
`define SDCR_RTC_MASK       16'h0001
`define SDCR_CLAIM_DLY      2

`endif

// [sdcr_pkg.sv]
/*
 * Types shared by the decode configuration bank.
 * Assumes sdcr_cfg.svh supplies the numeric constants.
 */
package sdcr_pkg;
    typedef enum logic [2:0] {
        SDCR_PP_COMPAT  = 3'b000,
        SDCR_PP_EXT     = 3'b001,
        SDCR_PP_EPP17   = 3'b010,
        SDCR_PP_EPP19   = 3'b011,
        SDCR_PP_ECP     = 3'b100,
        SDCR_PP_RSV5    = 3'b101,
        SDCR_PP_RSV6    = 3'b110,
        SDCR_PP_ECPEPP  = 3'b111
    } sdcr_ppmode_t;

    typedef enum logic [1:0] {
        SDCR_CL_IDLE  = 2'b00,
        SDCR_CL_WAIT  = 2'b01,
        SDCR_CL_CLAIM = 2'b10
    } sdcr_claim_t;

    // i/o range hit on a 16-bit port address; mask bits are don't-care
    function automatic logic sdcr_io_hit(input logic [15:0] a, input logic [15:0] b, input logic [15:0] m);
        sdcr_io_hit = ((a & ~m) == (b & ~m));
    endfunction
endpackage

// [sdcr_dec_if.sv]
/*
 * Carrier between the register bank and its address decoder.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/1ps
interface sdcr_dec_if;
    logic [15:0] fen;
    logic        alt_kbc;
    logic        kb_range;
    logic [7:0]  rom_en;
    logic [15:0] kb_base;
    logic [31:0] addr;
    logic        io_cyc;
    logic        mem_cyc;
    logic [15:0] fn_hit;
    logic        kbc_hit;
    logic        rtc_hit;
    logic        pm_hit;
    logic        rom_hit;
    logic        claim;

    modport bank (output fen, alt_kbc, kb_range, rom_en, kb_base, addr, io_cyc, mem_cyc,
                  input fn_hit, kbc_hit, rtc_hit, pm_hit, rom_hit, claim);
    modport dec  (input fen, alt_kbc, kb_range, rom_en, kb_base, addr, io_cyc, mem_cyc,
                  output fn_hit, kbc_hit, rtc_hit, pm_hit, rom_hit, claim);
endinterface

// [sdcr_addr_dec.sv]
/*
 * Combinational address decoder: which enabled function, chip select or option-rom
 * window a cycle hits.
 * Assumes address and cycle type are stable for the cycle in which they are decoded.
 */
`timescale 1ns/1ps
`include "sdcr_cfg.svh"
module sdcr_addr_dec (
    sdcr_dec_if.dec d
);
    import sdcr_pkg::*;

    // fixed legacy port ranges, listed from enable bit 15 down to bit 0; bit 13 uses the keyboard base
    localparam logic [15:0] FN_BASE [16] = '{16'h00b2, 16'h0061, 16'h0060, 16'h00c0, 16'h0000,
        16'h0040, 16'h0020, 16'h0070, 16'h0092, 16'h0000, 16'h0378, 16'h0170, 16'h02f8,
        16'h01f0, 16'h03f8, 16'h03f0};
    localparam logic [15:0] FN_MASK [16] = '{16'h0001, 16'h0000, 16'h0000, 16'h001f, 16'h000f,
        16'h0003, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0007, 16'h0007, 16'h0007,
        16'h0007, 16'h0007, 16'h0007};

    logic [15:0] pa;
    logic [15:0] raw;
    logic [15:0] kb_off;
    logic        kb_any;

    assign pa = d.addr[15:0];

    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_fn
            if (g == 6) begin : g_rsv
                assign raw[g] = 1'b0;
            end else if (g == 9) begin : g_pic
                assign raw[g] = sdcr_io_hit(pa, 16'h0020, 16'h0001) | sdcr_io_hit(pa, 16'h00a0, 16'h0001)
                              | sdcr_io_hit(pa, 16'h00f0, 16'h0000);
            end else if (g == `SDCR_FEN_KBC) begin : g_kbc
                // the power chip select needs the cycle claimed even when the range bit is clear
                assign raw[g] = d.kbc_hit | d.pm_hit;
            end else begin : g_fix
                assign raw[g] = sdcr_io_hit(pa, FN_BASE[15-g], FN_MASK[15-g]);
            end
        end
    endgenerate

    assign kb_off = pa - d.kb_base;
    assign kb_any = d.io_cyc && d.fen[`SDCR_FEN_KBC] && (kb_off[15:3] == 13'h0000) && !kb_off[0];

    always_comb begin
        d.kbc_hit = 1'b0;
        d.pm_hit  = 1'b0;
        if (kb_any) begin
            case (kb_off[2:0])
                3'h0, 3'h4: d.kbc_hit = 1'b1;
                3'h2, 3'h6: begin
                    d.kbc_hit = d.kb_range;
                    d.pm_hit  = d.alt_kbc;
                end
                default: d.kbc_hit = 1'b0;
            endcase
        end
    end

    assign d.rtc_hit = d.io_cyc && d.fen[`SDCR_FEN_RTC] && sdcr_io_hit(pa, `SDCR_RTC_BASE, `SDCR_RTC_MASK);

    assign d.rom_hit = d.mem_cyc && (d.addr[31:17] == 15'(`SDCR_ROM_BASE >> 17))
                     && d.rom_en[d.addr[16:`SDCR_ROM_WIN_LSB]];

    assign d.fn_hit = d.io_cyc ? (raw & d.fen) : 16'h0000;
    assign d.claim  = (|d.fn_hit) | d.rom_hit;
endmodule

// [sdcr_top.sv]
/*
 * Decode configuration register bank of the I/O function: function enables,
 * system I/O options, special functions, parallel-port mode, request-line-3
 * routing and option-rom windows, with the cycle claim and chip selects they steer.
 * Assumes configuration accesses arrive one byte at a time, and that bus cycles are
 * announced by a one-cycle start pulse with address and type valid in that cycle.
 */
`timescale 1ns/1ps
`include "sdcr_cfg.svh"
module sdcr_top #(
    parameter logic [7:0] PPID_VALUE = `SDCR_PPID_VAL // arbitrary identity value
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        function_default_strap_n,
    input  wire logic        cfg_rd,
    input  wire logic        cfg_wr,
    input  wire logic [7:0]  cfg_offset,
    input  wire logic [7:0]  cfg_wdata,
    output logic [7:0]       cfg_rdata,
    output logic             cfg_rd_valid,
    input  wire logic        cyc_start,
    input  wire logic        cyc_end,
    input  wire logic        cyc_io,
    input  wire logic        cyc_mem,
    input  wire logic [31:0] cyc_addr,
    input  wire logic [15:0] keyboard_ctrl_base,
    output logic             devsel_n,
    output logic [15:0]      function_hit,
    output logic             keyboard_ctrl_select_n,
    output logic             clock_chip_select_n,
    output logic             option_rom_select_n,
    input  wire logic        clock_latch_in,
    output logic             clock_chip_latch_pin,
    input  wire logic        floppy_on_parport_input,
    output logic             shared_pins_floppy,
    input  wire logic        port92_wr,
    input  wire logic [7:0]  port92_wdata,
    output logic             cmos_lock_38_3f,
    output logic             cmos_lock_19,
    input  wire logic [1:0]  fast_infrared_req,
    output logic [1:0]       fast_infrared_ack,
    output logic [1:0]       legacy_fir_req,
    input  wire logic [1:0]  legacy_fir_ack,
    output logic [1:0]       sg_fir_req,
    input  wire logic [1:0]  sg_fir_ack,
    input  wire logic        uart1_baud_clk,
    input  wire logic        uart1_dtr_core_n,
    output logic             uart1_dtr_pin_n,
    output logic             infrared_uart_mode,
    output logic             floppy_cfg_access_en,
    output logic             floppy_cfg_index_clear,
    input  wire logic        cpu_intr,
    output logic             serial_irq_sequence,
    output sdcr_pkg::sdcr_ppmode_t parport_mode,
    input  wire logic        parport_dir_bit,
    output logic             parport_data_oe,
    input  wire logic        expansion_dma_request3,
    output logic [7:0]       legacy_dma_req3,
    input  wire logic [7:0]  legacy_dma_ack_n,
    output logic             expansion_dma_ack3_n
);
    import sdcr_pkg::*;

    sdcr_dec_if dif ();

    logic [15:0] fen_q, fen_d;
    logic [7:0]  sio_q, sio_d;
    logic [7:0]  sfe_q, sfe_d;
    logic [7:0]  ppm_q, ppm_d;
    logic [7:0]  drt_q, drt_d;
    logic [7:0]  rom_q, rom_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        rdv_q, rdv_d;
    logic        lock38_q, lock38_d;
    logic        lock19_q, lock19_d;
    logic        fdc_clr_q, fdc_clr_d;
    logic        intr_q, intr_d;
    logic        sirq_q, sirq_d;
    sdcr_claim_t cl_q, cl_d;
    logic [15:0] hit_q, hit_d;
    logic        kbs_q, kbs_d;
    logic        rtcs_q, rtcs_d;
    logic        pms_q, pms_d;
    logic        roms_q, roms_d;

    assign dif.fen      = fen_q;
    assign dif.alt_kbc  = sio_q[`SDCR_SIO_ALTKBC];
    assign dif.kb_range = sio_q[`SDCR_SIO_KBRNG];
    assign dif.rom_en   = rom_q;
    assign dif.kb_base  = keyboard_ctrl_base;
    assign dif.addr     = cyc_addr;
    assign dif.io_cyc   = cyc_io;
    assign dif.mem_cyc  = cyc_mem;

    sdcr_addr_dec u_dec (
        .d (dif.dec)
    );

    // configuration registers: byte writes, reserved bits masked off on entry
    always_comb begin
        fen_d = fen_q;
        sio_d = sio_q;
        sfe_d = sfe_q;
        ppm_d = ppm_q;
        drt_d = drt_q;
        rom_d = rom_q;
        if (cfg_wr) begin
            case (cfg_offset)
                `SDCR_OFF_FEN_LO: fen_d[7:0]  = cfg_wdata & 8'(`SDCR_FEN_WMASK);
                `SDCR_OFF_FEN_HI: fen_d[15:8] = cfg_wdata;
                `SDCR_OFF_SIO:    sio_d = cfg_wdata;
                `SDCR_OFF_SFE:    sfe_d = cfg_wdata & `SDCR_SFE_WMASK;
                `SDCR_OFF_PPM:    ppm_d = cfg_wdata & `SDCR_PPM_WMASK;
                `SDCR_OFF_DRT3:   drt_d = cfg_wdata & `SDCR_DRT3_WMASK;
                `SDCR_OFF_ROM:    rom_d = cfg_wdata;
                default:          fen_d = fen_q;
            endcase
        end
        if (sys_rst) begin
            // strap sampled while reset is held, so the value present at release wins
            fen_d = function_default_strap_n ? `SDCR_FEN_STRAP_HI : `SDCR_FEN_STRAP_LO;
            sio_d = `SDCR_SIO_RST;
            sfe_d = `SDCR_SFE_RST;
            ppm_d = `SDCR_PPM_RST;
            drt_d = `SDCR_DRT3_RST;
            rom_d = `SDCR_ROM_RST;
        end
    end

    always_ff @(posedge mclk) begin
        fen_q <= fen_d;
        sio_q <= sio_d;
        sfe_q <= sfe_d;
        ppm_q <= ppm_d;
        drt_q <= drt_d;
        rom_q <= rom_d;
    end

    // read port: one cycle after the request, unmapped offsets read zero
    always_comb begin
        rdv_d   = cfg_rd && !sys_rst;
        rdata_d = 8'h00;
        if (cfg_rd) begin
            case (cfg_offset)
                `SDCR_OFF_FEN_LO: rdata_d = fen_q[7:0];
                `SDCR_OFF_FEN_HI: rdata_d = fen_q[15:8];
                `SDCR_OFF_SIO:    rdata_d = sio_q;
                `SDCR_OFF_SFE:    rdata_d = sfe_q;
                `SDCR_OFF_PPID:   rdata_d = PPID_VALUE;
                `SDCR_OFF_PPM:    rdata_d = ppm_q;
                `SDCR_OFF_DRT3:   rdata_d = drt_q;
                `SDCR_OFF_ROM:    rdata_d = rom_q;
                default:          rdata_d = 8'h00;
            endcase
        end
        if (sys_rst) begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        rdata_q <= rdata_d;
        rdv_q   <= rdv_d;
    end

    assign cfg_rdata    = rdata_q;
    assign cfg_rd_valid = rdv_q;

    // cmos locks are sticky until reset; a lock only takes effect if its option bit allows it
    always_comb begin
        lock38_d = lock38_q | (port92_wr & port92_wdata[`SDCR_P92_LOCK38] & sio_q[`SDCR_SIO_LOCK38]);
        lock19_d = lock19_q | (port92_wr & port92_wdata[`SDCR_P92_LOCK19] & sio_q[`SDCR_SIO_LOCK19]);
        fdc_clr_d = sfe_d[`SDCR_SFE_FDCCFG] & ~sfe_q[`SDCR_SFE_FDCCFG];
        intr_d   = cpu_intr;
        sirq_d   = cpu_intr & ~intr_q & sfe_q[`SDCR_SFE_SERIRQ];
        if (sys_rst) begin
            lock38_d  = 1'b0;
            lock19_d  = 1'b0;
            fdc_clr_d = 1'b0;
            intr_d    = 1'b0;
            sirq_d    = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        lock38_q  <= lock38_d;
        lock19_q  <= lock19_d;
        fdc_clr_q <= fdc_clr_d;
        intr_q    <= intr_d;
        sirq_q    <= sirq_d;
    end

    assign cmos_lock_38_3f        = lock38_q;
    assign cmos_lock_19           = lock19_q;
    assign floppy_cfg_index_clear = fdc_clr_q;
    assign floppy_cfg_access_en   = sfe_q[`SDCR_SFE_FDCCFG];
    assign serial_irq_sequence    = sirq_q;

    // claim sequencer: decode latched at the start, devsel from the second clock to the end
    always_comb begin
        cl_d   = cl_q;
        hit_d  = hit_q;
        kbs_d  = kbs_q;
        rtcs_d = rtcs_q;
        pms_d  = pms_q;
        roms_d = roms_q;
        case (cl_q)
            SDCR_CL_IDLE: begin
                if (cyc_start && dif.claim) begin
                    cl_d   = SDCR_CL_WAIT;
                    hit_d  = dif.fn_hit;
                    kbs_d  = dif.kbc_hit;
                    rtcs_d = dif.rtc_hit;
                    pms_d  = dif.pm_hit;
                    roms_d = dif.rom_hit;
                end
            end
            SDCR_CL_WAIT: cl_d = SDCR_CL_CLAIM;
            SDCR_CL_CLAIM: begin
                if (cyc_end) begin
                    cl_d   = SDCR_CL_IDLE;
                    hit_d  = 16'h0000;
                    kbs_d  = 1'b0;
                    rtcs_d = 1'b0;
                    pms_d  = 1'b0;
                    roms_d = 1'b0;
                end
            end
            default: cl_d = SDCR_CL_IDLE;
        endcase
        if (sys_rst) begin
            cl_d   = SDCR_CL_IDLE;
            hit_d  = 16'h0000;
            kbs_d  = 1'b0;
            rtcs_d = 1'b0;
            pms_d  = 1'b0;
            roms_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        cl_q   <= cl_d;
        hit_q  <= hit_d;
        kbs_q  <= kbs_d;
        rtcs_q <= rtcs_d;
        pms_q  <= pms_d;
        roms_q <= roms_d;
    end

    logic claiming;
    assign claiming               = (cl_q == SDCR_CL_CLAIM);
    assign devsel_n               = ~claiming;
    assign function_hit           = claiming ? hit_q : 16'h0000;
    // gate with the live enable too, so a disable written mid-cycle drops the select at once
    assign keyboard_ctrl_select_n = ~(claiming & kbs_q & fen_q[`SDCR_FEN_KBC]);
    assign option_rom_select_n    = ~(claiming & roms_q);
    // the clock-chip select only exists in the alternate keyboard configuration
    assign clock_chip_select_n    = ~(claiming & rtcs_q & sio_q[`SDCR_SIO_ALTKBC]);
    // latch pin: power chip select (active low) in alternate mode, else the latch itself
    assign clock_chip_latch_pin   = sio_q[`SDCR_SIO_ALTKBC] ? ~(claiming & pms_q) : clock_latch_in;

    // pin personalities and routing
    assign shared_pins_floppy = sio_q[`SDCR_SIO_PNF] & ~floppy_on_parport_input;
    assign legacy_fir_req     = sio_q[`SDCR_SIO_FIRSG] ? 2'b00 : fast_infrared_req;
    assign sg_fir_req         = sio_q[`SDCR_SIO_FIRSG] ? fast_infrared_req : 2'b00;
    assign fast_infrared_ack  = sio_q[`SDCR_SIO_FIRSG] ? sg_fir_ack : legacy_fir_ack;
    assign uart1_dtr_pin_n    = sio_q[`SDCR_SIO_BAUDT] ? uart1_baud_clk : uart1_dtr_core_n;
    assign infrared_uart_mode = sio_q[`SDCR_SIO_UIR];

    assign parport_mode = sdcr_ppmode_t'(ppm_q[2:0]);
    // compatible mode forces output; every other mode leaves direction to the port
    assign parport_data_oe = (parport_mode == SDCR_PP_COMPAT) ? 1'b1 : ~parport_dir_bit;

    // request line 3: no conflict check across sources, software keeps channels unique
    logic       drt_on;
    logic [2:0] drt_ch;
    assign drt_on = drt_q[`SDCR_DRT3_EN] && (drt_q[2:0] != `SDCR_DRT3_NONE);
    assign drt_ch = drt_q[2:0];
    assign legacy_dma_req3      = drt_on ? (8'(expansion_dma_request3) << drt_ch) : 8'h00;
    assign expansion_dma_ack3_n = drt_on ? legacy_dma_ack_n[drt_ch] : 1'b1;

    // checks
    kbc_gated_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !fen_q[`SDCR_FEN_KBC] |-> keyboard_ctrl_select_n) else $error("keyboard select while disabled");
    claim_time_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cl_q == SDCR_CL_IDLE && cyc_start && dif.claim) |=> devsel_n ##1 !devsel_n)
        else $error("devsel not on second clock");
    no_claim_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cl_q == SDCR_CL_IDLE && cyc_start && !dif.claim) |=> ##1 devsel_n)
        else $error("claim without enabled hit");
    strap_load_a: assert property (@(posedge mclk)
        $fell(sys_rst) |-> fen_q == ($past(function_default_strap_n) ? `SDCR_FEN_STRAP_HI : `SDCR_FEN_STRAP_LO))
        else $error("strap reset value wrong");
    lock38_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (port92_wr && port92_wdata[`SDCR_P92_LOCK38] && sio_q[`SDCR_SIO_LOCK38]) |=> cmos_lock_38_3f)
        else $error("cmos 38-3f lock missed");
    lock19_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!cmos_lock_19 && !(port92_wr && sio_q[`SDCR_SIO_LOCK19])) |=> !cmos_lock_19)
        else $error("cmos 19 lock without cause");
    fdc_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(floppy_cfg_access_en) |-> floppy_cfg_index_clear) else $error("index not cleared");
    sirq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!sfe_q[`SDCR_SFE_SERIRQ]) |=> !serial_irq_sequence) else $error("serial irq while off");
    pp_compat_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ppm_q[2:0] == 3'b000) |-> parport_data_oe) else $error("compat data not driven");
    dma_route_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !drt_q[`SDCR_DRT3_EN] |-> (legacy_dma_req3 == 8'h00 && expansion_dma_ack3_n))
        else $error("line 3 routed while off");
    pnf_mux_a: assert property (@(posedge mclk) disable iff (sys_rst)
        floppy_on_parport_input |-> !shared_pins_floppy) else $error("floppy on pins");

    claim_seen_c: cover property (@(posedge mclk) disable iff (sys_rst) $fell(devsel_n));
    rom_sel_c: cover property (@(posedge mclk) disable iff (sys_rst) !option_rom_select_n);
    pm_sel_c: cover property (@(posedge mclk) disable iff (sys_rst)
        sio_q[`SDCR_SIO_ALTKBC] && !clock_chip_latch_pin);
    lock_c: cover property (@(posedge mclk) disable iff (sys_rst) $rose(cmos_lock_38_3f));
endmodule

// [sdcr_host_model.sv]
/* Host bridge model: byte config accesses and single bus cycles toward the bank.
   Assumes the bank timing on mclk; released lines show inverted data. */
`timescale 1ns/1ps
module sdcr_host_model (
    input  wire logic        mclk,
    input  wire logic [7:0]  cfg_rdata,
    input  wire logic        cfg_rd_valid,
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [7:0]       cfg_offset,
    output logic [7:0]       cfg_wdata,
    output logic             cyc_start,
    output logic             cyc_end,
    output logic             cyc_io,
    output logic             cyc_mem,
    output logic [31:0]      cyc_addr
);
    initial {cfg_rd, cfg_wr, cfg_offset, cfg_wdata, cyc_start, cyc_end, cyc_io, cyc_mem, cyc_addr} = '0;
    // callers pass legal modes, one source per channel, zero upper route bits
    task automatic wr(input logic [7:0] o, input logic [7:0] d);
        @(posedge mclk) {cfg_wr, cfg_offset, cfg_wdata} <= {1'b1, o, d};
        @(posedge mclk) {cfg_wr, cfg_offset, cfg_wdata} <= {1'b0, ~o, ~d};
        #1;
    endtask
    task automatic rd(input logic [7:0] o, output logic [7:0] v);
        @(posedge mclk) {cfg_rd, cfg_offset} <= {1'b1, o};
        @(posedge mclk) {cfg_rd, cfg_offset} <= {1'b0, ~o};
        // data without its valid strobe comes back unknown and fails the compare
        @(posedge mclk) v = cfg_rd_valid ? cfg_rdata : 8'hxx;
    endtask
    task automatic start(input logic [31:0] a, input logic io);
        @(posedge mclk) {cyc_start, cyc_io, cyc_mem, cyc_addr} <= {1'b1, io, ~io, a};
        @(posedge mclk) {cyc_start, cyc_addr} <= {1'b0, ~a};
        @(posedge mclk);
    endtask
    task automatic stop_cyc();
        @(posedge mclk) cyc_end <= 1'b1;
        @(posedge mclk) cyc_end <= 1'b0;
        @(posedge mclk);
    endtask
endmodule

// [tb.sv]
/* Bench for the decode configuration bank: strap reset, register table, claims, pins, locks, pulses, routing.
   Assumes the host model owns config accesses and bus cycles; the bench drives the rest. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
    import sdcr_pkg::*;
    localparam logic [7:0] OFS [8] = '{8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5f, 8'h61, 8'h62, 8'h60};
    localparam logic [7:0] RDV [8] = '{8'hbf, 8'hff, 8'hff, 8'h03, 8'h07, 8'h0f, 8'hff, 8'h00};
    localparam logic [15:0] RT [5] = '{16'h0801, 16'h0d20, 16'h0f80, 16'h0c00, 16'h0500};
    localparam logic [15:0] LK [3] = '{16'h0028, 16'h0228, 16'h0620};
    int err_count = 0;
    int samples_checked = 0;
    logic [7:0] v;
    logic mclk = '0, sys_rst = '1, function_default_strap_n = '1, clock_latch_in = '0, floppy_on_parport_input = '0;
    logic port92_wr = '0, uart1_baud_clk = '0, cpu_intr = '0, parport_dir_bit = '1, expansion_dma_request3 = '0;
    logic uart1_dtr_core_n = '1, cfg_rd, cfg_wr, cyc_start, cyc_end, cyc_io, cyc_mem, cfg_rd_valid, devsel_n;
    logic keyboard_ctrl_select_n, clock_chip_select_n, option_rom_select_n, clock_chip_latch_pin, cmos_lock_19;
    logic shared_pins_floppy, cmos_lock_38_3f, infrared_uart_mode, uart1_dtr_pin_n, floppy_cfg_index_clear;
    logic serial_irq_sequence, parport_data_oe, expansion_dma_ack3_n, floppy_cfg_access_en;
    logic [1:0] fast_infrared_req = 2'h3, legacy_fir_ack = 2'h1, sg_fir_ack = 2'h2;
    logic [1:0] fast_infrared_ack, legacy_fir_req, sg_fir_req;
    logic [7:0] port92_wdata = '0, cfg_offset, cfg_wdata, cfg_rdata, legacy_dma_req3, legacy_dma_ack_n = 8'hde;
    logic [15:0] keyboard_ctrl_base = 16'h0060, function_hit;
    logic [31:0] cyc_addr;
    sdcr_ppmode_t parport_mode;
    wire logic [4:0] sel = {devsel_n, keyboard_ctrl_select_n, clock_chip_select_n, option_rom_select_n,
                            clock_chip_latch_pin};
    wire logic [3:0] pins = {shared_pins_floppy, infrared_uart_mode, uart1_dtr_pin_n, clock_chip_latch_pin};
    always #2 mclk = ~mclk;
    sdcr_host_model host (.*);
    sdcr_top DUT (.*);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic reg_is(input logic [7:0] o, input logic [7:0] e);
        host.rd(o, v);
        `CHK("cfg byte", e, v)
    endtask
    task automatic pulse_seen(ref logic s);
        for (int n = 0; n < 4 && s !== 1'b1; n++) @(posedge mclk) #1;
        `CHK("pulse", 1'b1, s)
    endtask
    // selects are looked at in cycle 2, the first cycle a claim may show
    task automatic bus(input logic [31:0] a, input logic io, input logic [4:0] e, input logic [15:0] h);
        host.start(a, io);
        #1;
        `CHK("claim", e, sel)
        `CHK("hits", h, function_hit)
        host.stop_cyc();
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= '0;
        reg_is(8'h5a, 8'hbf);
        reg_is(8'h5b, 8'hff);
        @(posedge mclk) {sys_rst, function_default_strap_n} <= 2'h2;
        repeat (12) @(posedge mclk);
        sys_rst <= '0;
        foreach (OFS[i]) reg_is(OFS[i], 8'h00);
        foreach (OFS[i]) host.wr(OFS[i], OFS[i] == 8'h61 ? 8'h0f : 8'hff);
        foreach (OFS[i]) reg_is(OFS[i], RDV[i]);
        for (int m = 0; m < 8; m++) begin
            if (m == 5 || m == 6) continue;
            @(posedge mclk) parport_dir_bit <= m[1];
            host.wr(8'h5f, 8'(m));
            `CHK("mode", 3'(m), parport_mode)
            `CHK("data oe", (m == 0) || !m[1], parport_data_oe)
        end
        $display("register test done");
        bus(32'h0000_0062, 1'b1, 5'h06, 16'h2000);
        bus(32'h0000_0070, 1'b1, 5'h0b, 16'h0100);
        bus(32'h0000_00b2, 1'b1, 5'h0f, 16'h8000);
        host.wr(8'h62, 8'h80);
        bus(32'h000d_bfff, 1'b0, 5'h1f, 16'h0000);
        bus(32'h000d_c000, 1'b0, 5'h0d, 16'h0000);
        host.wr(8'h5b, 8'hdf);
        @(posedge mclk) keyboard_ctrl_base <= 16'h0300;
        bus(32'h0000_0300, 1'b1, 5'h1f, 16'h0000);
        $display("cycle test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) {floppy_on_parport_input, clock_latch_in, uart1_baud_clk} <= {3{i[0]}};
            host.wr(8'h5c, i[1] ? 8'h69 : 8'h00);
            `CHK("pins", {(i == 2), i[1], (i[1] ? i[0] : 1'b1), i[0]}, pins)
            `CHK("fir", i[1] ? 6'h0e : 6'h31, {legacy_fir_req, sg_fir_req, fast_infrared_ack})
        end
        foreach (LK[i]) begin
            host.wr(8'h5c, LK[i][15:8]);
            @(posedge mclk) {port92_wr, port92_wdata} <= {1'b1, LK[i][7:0]};
            @(posedge mclk) {port92_wr, port92_wdata} <= {1'b0, ~LK[i][7:0]};
            @(posedge mclk) #1;
            `CHK("locks", (i == 0) ? 2'h0 : 2'(i + 1), {cmos_lock_38_3f, cmos_lock_19})
        end
        foreach (RT[i]) begin
            @(posedge mclk) expansion_dma_request3 <= i[0];
            host.wr(8'h61, RT[i][15:8]);
            `CHK("route", {RT[i][7:0] & {8{i[0]}}, ~|(RT[i][7:0] & 8'h21)}, {legacy_dma_req3, expansion_dma_ack3_n})
        end
        $display("option test done");
        host.wr(8'h5d, 8'h00);
        host.wr(8'h5d, 8'h01);
        pulse_seen(floppy_cfg_index_clear);
        `CHK("fdc cfg", 1'b1, floppy_cfg_access_en)
        host.wr(8'h5d, 8'h03);
        @(posedge mclk) cpu_intr <= '1;
        pulse_seen(serial_irq_sequence);
        $display("pulse test done");
        wrap_up();
    end
endmodule
